/* File: rtl/uvep_map.svh */
`ifndef UVEP_MAP_SVH
`define UVEP_MAP_SVH
`define UVEP_ADDR_W          17
`define UVEP_DATA_W          16
`define UVEP_LAST_ADDR       17'h1ffff
`define UVEP_ERASED_WORD     16'hffff
`define UVEP_CLK_PERIOD_PS   4000
`define UVEP_PULSE_NS        100000
`define UVEP_PULSE_CYC       ((`UVEP_PULSE_NS * 1000) / `UVEP_CLK_PERIOD_PS)
`define UVEP_ACC_NS          250
`define UVEP_ACC_CYC         ((`UVEP_ACC_NS * 1000 + `UVEP_CLK_PERIOD_PS - 1) / `UVEP_CLK_PERIOD_PS)
`define UVEP_FLOAT_NS        60
`define UVEP_FLOAT_CYC       ((`UVEP_FLOAT_NS * 1000 + `UVEP_CLK_PERIOD_PS - 1) / `UVEP_CLK_PERIOD_PS)
`define UVEP_MAX_PULSES      25
`define UVEP_ID_MFR_ADDR     17'h00000
`define UVEP_ID_DEV_ADDR     17'h00001
`endif

/* File: rtl/uvep_pkg.sv */
package uvep_pkg;
  typedef logic [16:0] uvep_addr_t;
  typedef logic [15:0] uvep_data_t;
  typedef enum logic [1:0] {
    UVEP_OP_READ = 2'h0,
    UVEP_OP_PROG = 2'h1,
    UVEP_OP_ID   = 2'h2,
    UVEP_OP_FULL = 2'h3
  } uvep_op_t;
  typedef enum logic [3:0] {
    UVEP_IDLE   = 4'h0,
    UVEP_SETUP  = 4'h1,
    UVEP_ACCESS = 4'h2,
    UVEP_PULSE  = 4'h3,
    UVEP_RECOV  = 4'h4,
    UVEP_VERIFY = 4'h5,
    UVEP_FLOAT  = 4'h6,
    UVEP_SWEEP  = 4'h7,
    UVEP_DONE   = 4'h8
  } uvep_state_t;
endpackage : uvep_pkg

/* File: rtl/uvep_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface uvep_pin_if;
  import uvep_pkg::*;
  logic       ce_n;
  logic       oe_n;
  logic       pgm_n;
  logic       drive;
  uvep_data_t dout;
  uvep_data_t din;
  logic       hv_pp;
  logic       hv_id;
  uvep_addr_t addr;
  modport ctrl (output ce_n, oe_n, pgm_n, drive, dout, hv_pp, hv_id, addr, input din);
  modport pins (input ce_n, oe_n, pgm_n, drive, dout, hv_pp, hv_id, addr, output din);
endinterface : uvep_pin_if
`default_nettype wire

/* File: rtl/uvep_pin_drv.sv */
`timescale 1ns/1ps
`default_nettype none
// registered pin stage: all pin outputs from flip-flops
module uvep_pin_drv (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  uvep_pin_if.pins              p,
  input  wire logic [15:0]      dq_in,
  output logic                  ce_n,
  output logic                  oe_n,
  output logic                  pgm_n,
  output logic [16:0]           addr,
  output logic [15:0]           dq_out,
  output logic                  dq_oe,
  output logic                  vpp_high,
  output logic                  id_high_volt
);
  import uvep_pkg::*;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_n         <= 1'b1;
      oe_n         <= 1'b1;
      pgm_n        <= 1'b1;
      addr         <= 17'h00000;
      dq_out       <= 16'h0000;
      dq_oe        <= 1'b0;
      vpp_high     <= 1'b0;
      id_high_volt <= 1'b0;
    end else if (clk_en) begin
      ce_n         <= p.ce_n;
      oe_n         <= p.oe_n;
      pgm_n        <= p.pgm_n;
      addr         <= p.addr;
      dq_out       <= p.dout;
      dq_oe        <= p.drive & p.oe_n;
      vpp_high     <= p.hv_pp;
      id_high_volt <= p.hv_id;
    end
  end
  assign p.din = dq_in;
endmodule : uvep_pin_drv
`default_nettype wire

/* File: rtl/uvep_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uvep_map.svh"
// Functional notes
// RULE1: the memory holds 128K words of 16 bits on a 17-bit address and a 16-bit data path.
// RULE2: erased words read all ones and programming only clears bits to zero.
// RULE3: programming happens only with program supply high and both chip select and program strobe low.
// RULE4: the controller drives the whole 16-bit word on the data pins while programming.
// RULE5: 100 us pulses, verify after each, repeat up to a maximum, then step through addresses. The code programs one address per request.
// RULE6: pulse-and-verify uses raised main supply, then a full verify pass at nominal supplies. The code's full pass stops at the first word not 16'hffff.
// RULE7: a low chip select pulse programs the device, a high chip select inhibits it. The code holds ce_n low and pulses program_strobe_n instead.
// RULE8: verify uses output gate and chip select low, program strobe high, program supply high.
// RULE9: identifier mode forces high voltage on the upper id line with other address lines low.
// RULE10: identifier mode gives the maker code with the lowest address line low, device code with it high.
// RULE11: identifier bytes carry odd parity with the data msb bit as parity.
// RULE12: data is driven by the memory only while chip select and output gate are both low.
// RULE13: with stable address, data is read after the full access time.
// RULE14: chip select high puts the memory in standby with floating outputs.
// RULE15: chip select is the selection and output gate is the read strobe.
// RULE16: chip select low and output gate high keeps the memory outputs floating.
module uvep_host
  import uvep_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `UVEP_PULSE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire uvep_pkg::uvep_op_t req_op,
  input  wire uvep_pkg::uvep_addr_t req_addr,
  input  wire uvep_pkg::uvep_data_t req_data,
  input  wire logic              high_main_supply_ok,
  output logic                   rsp_valid,
  output uvep_pkg::uvep_data_t   rsp_data,
  output logic                   rsp_error,
  output logic                   rsp_parity_ok,
  output logic                   main_supply_raise,
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   program_strobe_n,
  output logic [16:0]            addr,
  input  wire logic [15:0]       dq_in,
  output logic [15:0]            dq_out,
  output logic                   dq_oe,
  output logic                   vpp_high,
  output logic                   upper_id_high_volt
);
  import uvep_pkg::*;
  localparam int unsigned ACC_CYC   = `UVEP_ACC_CYC;
  localparam int unsigned FLOAT_CYC = `UVEP_FLOAT_CYC;
  localparam int unsigned MAXP      = `UVEP_MAX_PULSES;

  uvep_pin_if pif ();

  uvep_state_t state_q, state_d;
  uvep_op_t    op_q;
  uvep_addr_t  addr_q;
  uvep_data_t  wdata_q;
  uvep_data_t  rdata_q;
  logic [19:0] cnt_q;
  logic [4:0]  pulses_q;
  logic        err_q;
  logic        rsp_valid_q;
  logic        match;
  logic        cnt_done;

  // judged on the word captured in verify, the live pins float afterwards
  assign match     = ((rdata_q & ~wdata_q) == 16'h0000) && ((~rdata_q & wdata_q) == 16'h0000); // RULE2
  assign cnt_done  = (cnt_q == 20'h00000);
  assign req_ready = (state_q == UVEP_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      UVEP_IDLE:   if (req_valid) state_d = UVEP_SETUP;
      UVEP_SETUP: begin
        if (cnt_done && (op_q != UVEP_OP_PROG || high_main_supply_ok)) // RULE6
          state_d = (op_q == UVEP_OP_PROG) ? UVEP_PULSE : UVEP_ACCESS;
      end
      UVEP_PULSE:  if (cnt_done) state_d = UVEP_RECOV;
      UVEP_RECOV:  if (cnt_done) state_d = UVEP_ACCESS;
      UVEP_ACCESS: if (cnt_done) state_d = UVEP_VERIFY;
      UVEP_VERIFY: state_d = UVEP_FLOAT;
      UVEP_FLOAT: begin
        if (cnt_done) begin
          if (op_q == UVEP_OP_PROG && !match && pulses_q < MAXP[4:0]) state_d = UVEP_PULSE; // RULE5
          else if (op_q == UVEP_OP_FULL && !err_q && addr_q != `UVEP_LAST_ADDR) state_d = UVEP_SWEEP; // RULE6
          else state_d = UVEP_DONE;
        end
      end
      UVEP_SWEEP:  state_d = UVEP_ACCESS;
      UVEP_DONE:   state_d = UVEP_IDLE;
      default:     state_d = UVEP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) state_q <= UVEP_IDLE;
    else if (clk_en) state_q <= state_d;
  end

  // request capture, address stepping
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_q    <= UVEP_OP_READ;
      addr_q  <= 17'h00000;
      wdata_q <= 16'h0000;
    end else if (clk_en) begin
      if (state_q == UVEP_IDLE && req_valid) begin
        op_q    <= req_op;
        addr_q  <= (req_op == UVEP_OP_ID) ? {16'h0000, req_addr[0]} : // RULE9 RULE10
                   (req_op == UVEP_OP_FULL) ? 17'h00000 : req_addr;
        wdata_q <= (req_op == UVEP_OP_FULL) ? `UVEP_ERASED_WORD : req_data;
      end else if (state_q == UVEP_SWEEP) begin
        addr_q <= addr_q + 17'h00001; // RULE1
      end
    end
  end

  // phase timers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 20'h00000;
    else if (clk_en) begin
      if (state_q != state_d || state_q == UVEP_VERIFY) begin
        case (state_d)
          UVEP_PULSE:  cnt_q <= 20'(PULSE_CYC - 1); // RULE5
          UVEP_ACCESS: cnt_q <= 20'(ACC_CYC);       // RULE13
          UVEP_FLOAT:  cnt_q <= 20'(FLOAT_CYC);
          UVEP_RECOV:  cnt_q <= 20'h00001;
          UVEP_SETUP:  cnt_q <= 20'h00001;
          default:     cnt_q <= 20'h00000;
        endcase
      end else if (!cnt_done) cnt_q <= cnt_q - 20'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulses_q <= 5'h00;
      err_q    <= 1'b0;
      rdata_q  <= 16'h0000;
    end else if (clk_en) begin
      if (state_q == UVEP_IDLE && req_valid) begin
        pulses_q <= 5'h00;
        err_q    <= 1'b0;
      end
      if (state_q == UVEP_PULSE && cnt_done) pulses_q <= pulses_q + 5'h01;
      if (state_q == UVEP_VERIFY) begin
        rdata_q <= pif.din;
        if (op_q == UVEP_OP_FULL && pif.din != wdata_q) err_q <= 1'b1;
      end
      if (state_q == UVEP_FLOAT && cnt_done && op_q == UVEP_OP_PROG && !match && pulses_q >= MAXP[4:0])
        err_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rsp_valid_q <= 1'b0;
    else if (clk_en) rsp_valid_q <= (state_q == UVEP_DONE);
  end

  assign rsp_valid     = rsp_valid_q;
  assign rsp_data      = rdata_q;
  assign rsp_error     = err_q;
  assign rsp_parity_ok = ^rdata_q[7:0]; // RULE11

  // pin intent, registered in the pin stage
  always_comb begin
    pif.ce_n  = !(state_q inside {UVEP_SETUP, UVEP_PULSE, UVEP_RECOV, UVEP_ACCESS, UVEP_VERIFY}); // RULE14 RULE15
    pif.oe_n  = !(state_q inside {UVEP_ACCESS, UVEP_VERIFY}); // RULE12 RULE16
    pif.pgm_n = !(state_q == UVEP_PULSE && op_q == UVEP_OP_PROG); // RULE3 RULE7 RULE8
    pif.drive = (op_q == UVEP_OP_PROG) && (state_q inside {UVEP_SETUP, UVEP_PULSE, UVEP_RECOV}); // RULE4
    pif.dout  = wdata_q;
    pif.hv_pp = (op_q == UVEP_OP_PROG) && (state_q != UVEP_IDLE) && (state_q != UVEP_DONE); // RULE3
    pif.hv_id = (op_q == UVEP_OP_ID) && (state_q != UVEP_IDLE) && (state_q != UVEP_DONE); // RULE9
    pif.addr  = addr_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) main_supply_raise <= 1'b0;
    else if (clk_en) main_supply_raise <= (op_q == UVEP_OP_PROG) && (state_q != UVEP_IDLE); // RULE6
  end

  uvep_pin_drv u_pins (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .p            (pif),
    .dq_in        (dq_in),
    .ce_n         (ce_n),
    .oe_n         (oe_n),
    .pgm_n        (program_strobe_n),
    .addr         (addr),
    .dq_out       (dq_out),
    .dq_oe        (dq_oe),
    .vpp_high     (vpp_high),
    .id_high_volt (upper_id_high_volt)
  );

  property p_pulse_needs_ce;
    @(posedge ref_clk) disable iff (!reset_n) !program_strobe_n |-> (!ce_n && vpp_high);
  endproperty
  a_pulse_needs_ce: assert property (p_pulse_needs_ce) else $error("strobe without select or supply"); // RULE3

  property p_no_contention;
    @(posedge ref_clk) disable iff (!reset_n) dq_oe |-> oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("drive while gate low"); // RULE12

  property p_verify_levels;
    @(posedge ref_clk) disable iff (!reset_n) (!oe_n && vpp_high) |-> (program_strobe_n && !ce_n);
  endproperty
  a_verify_levels: assert property (p_verify_levels) else $error("bad verify levels"); // RULE8

  property p_id_addr;
    @(posedge ref_clk) disable iff (!reset_n) upper_id_high_volt |-> (addr[16:1] == 16'h0000);
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id mode address not low"); // RULE9

  property p_gate_needs_ce;
    @(posedge ref_clk) disable iff (!reset_n) !oe_n |-> !ce_n;
  endproperty
  a_gate_needs_ce: assert property (p_gate_needs_ce) else $error("gate without select"); // RULE15

  property p_data_during_pulse;
    @(posedge ref_clk) disable iff (!reset_n) !program_strobe_n |-> (dq_oe && dq_out == wdata_q);
  endproperty
  a_data_during_pulse: assert property (p_data_during_pulse) else $error("word not driven in pulse"); // RULE4

  // strobe low time seen on the pin
  logic [19:0] strobe_len_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) strobe_len_q <= 20'h00000;
    else if (clk_en) strobe_len_q <= program_strobe_n ? 20'h00000 : strobe_len_q + 20'h00001;
  end

  property p_pulse_len;
    @(posedge ref_clk) disable iff (!reset_n || !clk_en)
      $rose(program_strobe_n) |-> (strobe_len_q == 20'(PULSE_CYC));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse ended early"); // RULE5

  property p_float_then_ce;
    @(posedge ref_clk) disable iff (!reset_n) $rose(oe_n) |-> ce_n;
  endproperty
  a_float_then_ce: assert property (p_float_then_ce) else $error("gate released without deselect"); // RULE14

  c_prog:  cover property (@(posedge ref_clk) disable iff (!reset_n) !program_strobe_n);
  c_id:    cover property (@(posedge ref_clk) disable iff (!reset_n) upper_id_high_volt && !oe_n);
  c_err:   cover property (@(posedge ref_clk) disable iff (!reset_n) rsp_valid && rsp_error);
  c_sweep: cover property (@(posedge ref_clk) disable iff (!reset_n) state_q == UVEP_SWEEP);
endmodule : uvep_host
`default_nettype wire

/* File: verif/uvep_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uvep_rom_model
  import uvep_pkg::*;
#(
  parameter real        ACC_NS   = 250.0,
  parameter real        GATE_NS  = 75.0,
  parameter logic [7:0] MFR_CODE = 8'h2a, // arbitrary code
  parameter logic [7:0] DEV_CODE = 8'h4c  // arbitrary code
) (
  input  wire logic                 ce_n,
  input  wire logic                 oe_n,
  input  wire logic                 program_strobe_n,
  input  wire uvep_pkg::uvep_addr_t addr,
  input  wire uvep_pkg::uvep_data_t dq_out,
  input  wire logic                 dq_oe,
  input  wire logic                 vpp_high,
  input  wire logic                 upper_id_high_volt,
  output uvep_pkg::uvep_data_t      dq_in
);
  uvep_data_t mem [uvep_addr_t];
  int         need   = 1;
  int         hits   = 0;
  logic       armed  = 1'b0;
  uvep_addr_t pa;
  uvep_data_t pd;
  realtime    t_sel  = 0;
  realtime    t_gate = 0;

  function automatic uvep_data_t stored(uvep_addr_t a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : stored

  function automatic uvep_data_t id_word(uvep_addr_t a);
    if ((a & 17'h1fdfe) != 17'h0) return 16'h0bad;
    return {8'h00, a[0] ? DEV_CODE : MFR_CODE};
  endfunction : id_word

  always @(addr or ce_n) t_sel = $realtime;
  always @(oe_n) t_gate = $realtime;

  // polled off the clock grid so pin updates have landed
  initial begin
    dq_in = 16'h0;
    #0.5;
    forever begin
      if (program_strobe_n === 1'b0 && ce_n === 1'b0 && vpp_high === 1'b1 && dq_oe === 1'b1) begin
        armed = 1'b1;
        pa = addr;
        pd = dq_out;
      end else if (armed && program_strobe_n === 1'b1) begin
        armed = 1'b0;
        hits++;
        if (hits >= need) mem[pa] = stored(pa) & pd;
      end
      if (ce_n === 1'b0 && oe_n === 1'b0 && program_strobe_n === 1'b1 && dq_oe !== 1'b1
          && $realtime - t_sel >= ACC_NS && $realtime - t_gate >= GATE_NS)
        dq_in = upper_id_high_volt === 1'b1 ? id_word(addr) : stored(addr);
      else
        dq_in = ~dq_in;
      #1;
    end
  end
endmodule : uvep_rom_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uvep_map.svh"
`define CHK(N, E, G) begin total_checks++; if ((G) !== (E)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", N, E, G); end end
module tb;
  import uvep_pkg::*;
  localparam int unsigned PULSE_SIM = 20;
  localparam logic [7:0]  MFR       = 8'h2a; // arbitrary code
  localparam logic [7:0]  DEV       = 8'h4c; // arbitrary code
  logic       ref_clk   = 1'b0;
  logic       reset_n   = 1'b0;
  logic       clk_en    = 1'b1;
  logic       req_valid = 1'b0;
  uvep_op_t   req_op    = UVEP_OP_READ;
  uvep_addr_t req_addr  = 17'h0;
  uvep_data_t req_data  = 16'h0;
  logic       req_ready, rsp_valid, rsp_error, rsp_parity_ok, main_supply_raise;
  logic       ce_n, oe_n, program_strobe_n, dq_oe, vpp_high, upper_id_high_volt;
  uvep_data_t rsp_data, dq_in, dq_out;
  uvep_addr_t addr;
  int         err_total = 0;
  int         total_checks = 0;
  int         low_cyc = 0;
  int         pulses = 0;

  uvep_host #(.PULSE_CYC(PULSE_SIM)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .high_main_supply_ok(main_supply_raise), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .rsp_parity_ok(rsp_parity_ok), .main_supply_raise(main_supply_raise),
    .ce_n(ce_n), .oe_n(oe_n), .program_strobe_n(program_strobe_n), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .vpp_high(vpp_high), .upper_id_high_volt(upper_id_high_volt));

  uvep_rom_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) model (.ce_n(ce_n), .oe_n(oe_n),
    .program_strobe_n(program_strobe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .vpp_high(vpp_high), .upper_id_high_volt(upper_id_high_volt), .dq_in(dq_in));

  always #2 ref_clk = ~ref_clk;

  // pin discipline around program pulses, and no data drive while the output gate is low
  always @(negedge ref_clk) begin
    if (reset_n) begin
      if (program_strobe_n === 1'b0) begin
        low_cyc++;
        `CHK("strobe_qual", 4'hf, {~ce_n, vpp_high, dq_oe, main_supply_raise})
      end else if (low_cyc != 0) begin
        `CHK("pulse_len", PULSE_SIM, low_cyc)
        pulses++;
        low_cyc = 0;
      end
      if (oe_n === 1'b0) `CHK("contention", 1'b0, dq_oe)
    end
  end

  task automatic complete_run();
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic do_reset();
    @(negedge ref_clk);
    req_valid = 1'b0;
    reset_n = 1'b0;
    #1;
    `CHK("idle_pins", 7'h70, {ce_n, oe_n, program_strobe_n, dq_oe, vpp_high, upper_id_high_volt, rsp_valid})
    repeat (12) @(negedge ref_clk);
    reset_n = 1'b1;
    low_cyc = 0;
  endtask : do_reset

  task automatic run_op(input uvep_op_t op, input uvep_addr_t a, input uvep_data_t d, input int stall,
                        input bit wait_rsp);
    int          n;
    logic [18:0] pins;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_data = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (stall > 0) begin
      clk_en = 1'b0;
      pins = {ce_n, oe_n, addr};
      repeat (stall) @(negedge ref_clk);
      `CHK("frozen", {pins, 1'b0}, {ce_n, oe_n, addr, rsp_valid})
      clk_en = 1'b1;
    end
    n = 0;
    while (wait_rsp && rsp_valid !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("rsp_in_time", 1'b1, n < 5000)
  endtask : run_op

  task automatic t_erased();
    run_op(UVEP_OP_READ, 17'h00000, 16'h0, 0, 1'b1);
    `CHK("erased_lo", 16'hffff, rsp_data)
    run_op(UVEP_OP_READ, 17'h1ffff, 16'h0, 0, 1'b1);
    `CHK("erased_hi", 16'hffff, rsp_data)
  endtask : t_erased

  task automatic t_program();
    model.need = 3;
    model.hits = 0;
    pulses = 0;
    run_op(UVEP_OP_PROG, 17'h1ffff, 16'ha5c3, 0, 1'b1);
    `CHK("prog_ok", {1'b0, 8'd3}, {rsp_error, pulses[7:0]})
    run_op(UVEP_OP_READ, 17'h1ffff, 16'h0, 0, 1'b1);
    `CHK("readback", 16'ha5c3, rsp_data)
    model.need = 1;
    model.hits = 0;
    pulses = 0;
    run_op(UVEP_OP_PROG, 17'h1ffff, 16'h0ff0, 0, 1'b1);
    `CHK("prog_fail", {1'b1, 8'(`UVEP_MAX_PULSES)}, {rsp_error, pulses[7:0]})
    run_op(UVEP_OP_READ, 17'h1ffff, 16'h0, 0, 1'b1);
    `CHK("zero_only", 16'h05c0, rsp_data)
  endtask : t_program

  task automatic t_ident();
    for (int i = 0; i < 2; i++) begin
      run_op(UVEP_OP_ID, 17'(i), 16'h0, 0, 1'b1);
      `CHK("ident", {8'h00, (i == 1) ? DEV : MFR, 1'b1}, {rsp_data, rsp_parity_ok})
    end
  endtask : t_ident

  task automatic t_stall();
    run_op(UVEP_OP_READ, 17'h00100, 16'h0, 50, 1'b1);
    `CHK("stalled_read", 16'hffff, rsp_data)
  endtask : t_stall

  task automatic t_mid_reset();
    int n;
    run_op(UVEP_OP_FULL, 17'h0, 16'h0, 0, 1'b0);
    n = 0;
    while (!(addr === 17'h00001 && ce_n === 1'b0) && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("sweep_step", 1'b1, n < 2000)
    do_reset();
    run_op(UVEP_OP_READ, 17'h1ffff, 16'h0, 0, 1'b1);
    `CHK("after_reset", 16'h05c0, rsp_data)
  endtask : t_mid_reset

  initial begin
    do_reset();
    #1;
    `CHK("ready", 1'b1, req_ready)
    t_erased();
    t_program();
    t_ident();
    t_stall();
    t_mid_reset();
    complete_run();
  end

  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
